/* rtl/plc_logic_cell.sv */
// One programmable logic cell with its APB configuration slave
//
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module plc_logic_cell #(
    parameter int CELLS_PER_GROUP = 8,
    parameter int CELL_POS        = 0,
    parameter int NUM_DEDICATED   = 6,
    parameter int NUM_GLOBAL      = 4
) (
    // Clock and reset
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    // APB slave
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [plc_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                pwdata,
    output logic                            pready,
    output logic [31:0]                     prdata,
    output logic                            pslverr,
    // Fabric inputs
    input  wire plc_pkg::plc_cell_in_type   cell_in,
    input  wire logic [NUM_DEDICATED-1:0]   dedicated_in,
    input  wire logic [NUM_GLOBAL-1:0]      global_int,
    input  wire logic                       ctrl_int,
    // Fabric outputs
    output logic                            local_out,
    output logic                            row_out,
    output logic                            carry_next_out,
    output logic                            carry_group_out,
    output logic                            cascade_out
);

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    localparam int LAST_POS = CELLS_PER_GROUP - 1;

    plc_pkg::plc_cfg_type       cfg_reg;
    logic [31:0]                lut_reg;
    logic [NUM_DEDICATED-1:0]   ded_s1_reg;
    logic [NUM_DEDICATED-1:0]   ded_s2_reg;
    logic [NUM_DEDICATED-1:0]   ded_s3_reg;
    logic [NUM_DEDICATED-1:0]   ded_f_reg;
    logic [NUM_GLOBAL-1:0]      glob;
    logic [plc_pkg::CTRL_N-1:0] ctrl_vec;
    logic                       clk_line;
    logic                       clk_prev_reg;
    logic                       clk_event;
    logic                       clr_on;
    logic                       pre_on;
    logic                       ena_on;
    logic                       carry_in;
    logic                       sel4;
    logic [3:0]                 idx4;
    logic [2:0]                 idx3;
    logic                       comb_val;
    logic                       carry_val;
    logic                       cas_val;
    logic                       reg_din;
    logic                       k_in;
    logic                       q_reg;
    logic                       q_next;
    logic [3:0]                 data_vec;
    logic                       pready_reg;
    logic [31:0]                prdata_reg;
    logic                       pslverr_reg;
    logic                       local_out_reg;
    logic                       row_out_reg;
    logic                       carry_next_reg;
    logic                       carry_group_reg;
    logic                       cascade_reg;
    logic                       wr_en;
    logic [31:0]                rd_mux;
    logic                       addr_err;

    // ----------------------------------------
    // APB slave
    // ----------------------------------------
    assign wr_en = psel & penable & pready_reg & pwrite;

    always_comb
    begin
        rd_mux   = '0;
        addr_err = 1'b0;
        case (paddr)
            plc_pkg::ADDR_CFG:  rd_mux = cfg_reg;
            plc_pkg::ADDR_LUT:  rd_mux = lut_reg;
            plc_pkg::ADDR_STAT:
            begin
                rd_mux[0]    = q_reg;
                rd_mux[1]    = local_out_reg;
                rd_mux[2]    = row_out_reg;
                rd_mux[3]    = carry_val;
                rd_mux[4]    = cascade_reg;
                rd_mux[15:8] = {{(8 - NUM_DEDICATED){1'b0}}, ded_f_reg};
                addr_err     = pwrite;
            end
            default:            addr_err = 1'b1;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_reg  <= 1'b0;
            prdata_reg  <= '0;
            pslverr_reg <= 1'b0;
        end
        else
        begin
            pready_reg  <= psel & ~penable;
            prdata_reg  <= (psel & ~penable & ~pwrite) ? rd_mux : '0;
            pslverr_reg <= psel & ~penable & addr_err;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg_reg <= plc_pkg::CFG_RESET;
            lut_reg <= plc_pkg::LUT_RESET;
        end
        else if (wr_en)
        begin
            if (paddr == plc_pkg::ADDR_CFG)
                cfg_reg <= pwdata;
            if (paddr == plc_pkg::ADDR_LUT)
                lut_reg <= pwdata;
        end
    end

    assign pready  = pready_reg;
    assign prdata  = prdata_reg;
    assign pslverr = pslverr_reg;

    // ----------------------------------------
    // Dedicated input synchronisers
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ded_s1_reg <= '0;
            ded_s2_reg <= '0;
            ded_s3_reg <= '0;
            ded_f_reg  <= '0;
        end
        else
        begin
            ded_s1_reg <= dedicated_in;
            ded_s2_reg <= ded_s1_reg;
            ded_s3_reg <= ded_s2_reg;
            for (int i = 0; i < NUM_DEDICATED; i++)
            begin
                if (ded_s2_reg[i] == ded_s3_reg[i])
                    ded_f_reg[i] <= ded_s3_reg[i];
            end
        end
    end

    // ----------------------------------------
    // Global lines and control selection
    // ----------------------------------------
    for (genvar g = 0; g < NUM_GLOBAL; g++)
    begin : g_glob
        assign glob[g] = cfg_reg.glob_src[g] ? global_int[g] : ded_f_reg[g];
    end

    assign ctrl_vec  = {1'b0, ctrl_int,
                        ded_f_reg[NUM_DEDICATED-1:NUM_GLOBAL], glob};
    assign clk_line  = ctrl_vec[cfg_reg.clk_sel];
    assign clr_on    = ctrl_vec[cfg_reg.clr_sel];
    assign pre_on    = ctrl_vec[cfg_reg.pre_sel];
    assign ena_on    = (cfg_reg.ena_sel == plc_pkg::SEL_NONE) |
                       ctrl_vec[cfg_reg.ena_sel];
    assign clk_event = clk_line & ~clk_prev_reg;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            clk_prev_reg <= 1'b0;
        else
            clk_prev_reg <= clk_line;
    end

    // ----------------------------------------
    // Carry entry
    // ----------------------------------------
    always_comb
    begin
        if (cfg_reg.chain_start)
            carry_in = 1'b0;
        else if (CELL_POS == 0)
            carry_in = cell_in.carry_group;
        else
            carry_in = cell_in.carry_prev;
    end

    // ----------------------------------------
    // Lookup tables per mode
    // ----------------------------------------
    assign data_vec = {cell_in.fourth_data_input, cell_in.third_data_input,
                       cell_in.second_data, cell_in.first_data};
    always_comb
    begin
        sel4 = cell_in.fourth_data_input;
        if (cfg_reg.carry_to_lut)
            sel4 = carry_in;
        else if (cfg_reg.pack == plc_pkg::PACK_DIRECT)
            sel4 = 1'b0;
        idx4 = {sel4, cell_in.third_data_input, cell_in.second_data,
                cell_in.first_data};
        idx3 = '0;
        comb_val  = 1'b0;
        carry_val = 1'b0;
        reg_din   = 1'b0;
        case (cfg_reg.mode)
            plc_pkg::MODE_NORMAL:
            begin
                comb_val = lut_reg[idx4];
                reg_din  = comb_val;
            end
            plc_pkg::MODE_ARITH:
            begin
                idx3      = {carry_in, cell_in.second_data, cell_in.first_data};
                comb_val  = lut_reg[{1'b0, idx3}];
                carry_val = lut_reg[{1'b1, idx3}];
                reg_din   = comb_val;
            end
            plc_pkg::MODE_COUNT:
            begin
                idx3      = {carry_in, cell_in.first_data, q_reg};
                comb_val  = lut_reg[{1'b0, idx3}];
                carry_val = lut_reg[{1'b1, idx3}];
                if (cell_in.third_data_input)
                    reg_din = cell_in.fourth_data_input;
                else if (cell_in.second_data)
                    reg_din = comb_val;
                else
                    reg_din = q_reg;
            end
            default: comb_val = 1'b0;
        endcase
        if (cfg_reg.mode != plc_pkg::MODE_COUNT)
        begin
            if (cfg_reg.pack == plc_pkg::PACK_DIRECT)
                reg_din = cell_in.fourth_data_input;
            else if (cfg_reg.pack == plc_pkg::PACK_SHARED)
                reg_din = data_vec[cfg_reg.pack_idx];
        end
    end

    // Cascade combine, also in arithmetic mode
    always_comb
    begin
        if (!cfg_reg.cas_en)
            cas_val = comb_val;
        else if (cfg_reg.cas_or)
            cas_val = comb_val | cell_in.cascade;
        else
            cas_val = comb_val & cell_in.cascade;
    end

    // ----------------------------------------
    // Programmable register
    // ----------------------------------------
    assign k_in = cell_in.third_data_input;
    always_comb
    begin
        case (cfg_reg.ff)
            plc_pkg::FF_D:  q_next = reg_din;
            plc_pkg::FF_T:  q_next = q_reg ^ reg_din;
            plc_pkg::FF_JK: q_next = (reg_din & ~q_reg) | (~k_in & q_reg);
            plc_pkg::FF_SR: q_next = reg_din | (~k_in & q_reg);
            default:        q_next = q_reg;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            q_reg <= 1'b0;
        else if (clr_on)
            q_reg <= 1'b0;
        else if (pre_on)
            q_reg <= 1'b1;
        else if (clk_event && ena_on)
            q_reg <= q_next;
    end

    // ----------------------------------------
    // Output routing
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            local_out_reg <= 1'b0;
            row_out_reg   <= 1'b0;
            cascade_reg   <= 1'b0;
        end
        else
        begin
            cascade_reg <= cas_val;
            if (cfg_reg.bypass)
            begin
                local_out_reg <= cas_val;
                row_out_reg   <= cas_val;
            end
            else
            begin
                local_out_reg <= cfg_reg.local_sel ? q_reg : cas_val;
                row_out_reg   <= cfg_reg.row_sel ? q_reg : cas_val;
            end
        end
    end

    // ----------------------------------------
    // Carry exits
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            carry_next_reg  <= 1'b0;
            carry_group_reg <= 1'b0;
        end
        else if (cfg_reg.chain_end)
        begin
            carry_next_reg  <= 1'b0;
            carry_group_reg <= 1'b0;
        end
        else
        begin
            carry_next_reg  <= (CELL_POS != LAST_POS) & carry_val;
            carry_group_reg <= (CELL_POS == LAST_POS) & carry_val;
        end
    end

    assign local_out       = local_out_reg;
    assign row_out         = row_out_reg;
    assign cascade_out     = cascade_reg;
    assign carry_next_out  = carry_next_reg;
    assign carry_group_out = carry_group_reg;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking ck @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_CLEAR_WINS: assert property (clr_on |=> !q_reg)
        else $error("clear did not force register low");

    AST_PRESET: assert property (!clr_on && pre_on |=> q_reg)
        else $error("preset did not force register high");

    AST_HOLD: assert property (
        !clr_on && !pre_on && !(clk_event && ena_on) |=> $stable(q_reg))
        else $error("register changed without clock edge and enable");

    AST_TOGGLE: assert property (
        cfg_reg.ff == plc_pkg::FF_T && clk_event && ena_on && !clr_on && !pre_on
        && reg_din |=> q_reg != $past(q_reg))
        else $error("toggle register did not toggle");

    AST_BYPASS_OUT: assert property (
        cfg_reg.bypass ##1 cfg_reg.bypass |-> local_out_reg == row_out_reg)
        else $error("bypass outputs differ");

    AST_ROUTES: assert property (
        !cfg_reg.bypass && cfg_reg.local_sel && !cfg_reg.row_sel
        |=> local_out_reg == $past(q_reg) && row_out_reg == $past(cas_val))
        else $error("packed outputs not routed independently");

    AST_CHAIN_END: assert property (
        cfg_reg.chain_end |=> !carry_next_out && !carry_group_out)
        else $error("carry left a terminated chain");

    AST_LOAD: assert property (
        cfg_reg.mode == plc_pkg::MODE_COUNT && cfg_reg.ff == plc_pkg::FF_D
        && cell_in.third_data_input && clk_event && ena_on && !clr_on && !pre_on
        |=> q_reg == $past(cell_in.fourth_data_input))
        else $error("counter load not taken on clock edge");

    AST_PACK_DIRECT: assert property (
        cfg_reg.mode == plc_pkg::MODE_NORMAL && cfg_reg.ff == plc_pkg::FF_D
        && cfg_reg.pack == plc_pkg::PACK_DIRECT && clk_event && ena_on
        && !clr_on && !pre_on |=> q_reg == $past(cell_in.fourth_data_input))
        else $error("direct packed load failed");

    AST_APB_READY: assert property (
        psel && !penable |=> pready ##1 !pready)
        else $error("ready not one cycle after setup");
endmodule : plc_logic_cell

`default_nettype wire

/* rtl/plc_pkg.sv */
// Constants, field layouts and carriers for the programmable logic cell
package plc_pkg;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam int          ADDR_W    = 12;
    localparam logic [11:0] ADDR_CFG  = 12'h000;
    localparam logic [11:0] ADDR_LUT  = 12'h004;
    localparam logic [11:0] ADDR_STAT = 12'h008;
    localparam logic [31:0] CFG_RESET = 32'h0fff0010;
    localparam logic [31:0] LUT_RESET = 32'h00000000;

    // ----------------------------------------
    // Control selection
    // ----------------------------------------
    localparam logic [2:0] SEL_NONE = 3'h7;
    localparam int         CTRL_N   = 8;

    // ----------------------------------------
    // Modes and options
    // ----------------------------------------
    typedef enum logic [1:0] {
        MODE_NORMAL = 2'h0,
        MODE_ARITH  = 2'h1,
        MODE_COUNT  = 2'h2
    } plc_mode_type;

    typedef enum logic [1:0] {
        FF_D  = 2'h0,
        FF_T  = 2'h1,
        FF_JK = 2'h2,
        FF_SR = 2'h3
    } plc_ff_type;

    typedef enum logic [1:0] {
        PACK_NONE   = 2'h0,
        PACK_DIRECT = 2'h1,
        PACK_SHARED = 2'h2
    } plc_pack_type;

    // ----------------------------------------
    // Carriers
    // ----------------------------------------
    typedef struct packed {
        logic [3:0]   glob_src;
        logic [2:0]   clk_sel;
        logic [2:0]   clr_sel;
        logic [2:0]   pre_sel;
        logic [2:0]   ena_sel;
        logic [1:0]   pack_idx;
        plc_pack_type pack;
        logic         cas_or;
        logic         cas_en;
        logic         chain_end;
        logic         chain_start;
        logic         carry_to_lut;
        logic         row_sel;
        logic         local_sel;
        logic         bypass;
        plc_ff_type   ff;
        plc_mode_type mode;
    } plc_cfg_type;

    typedef struct packed {
        logic first_data;
        logic second_data;
        logic third_data_input;
        logic fourth_data_input;
        logic carry_prev;
        logic carry_group;
        logic cascade;
    } plc_cell_in_type;

endpackage : plc_pkg

/* testbench/plc_fabric_model.sv */
// Lower neighbour cell of the fabric driving the chain inputs
`timescale 1ns/1ps
`default_nettype none

module plc_fabric_model (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Neighbour results
    input  wire logic carry_src,
    input  wire logic cascade_src,
    // Chain lines into the cell
    output logic      carry_prev,
    output logic      cascade
);
    // ----------------------------------------
    // Neighbour output registers
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            carry_prev <= 1'b0;
            cascade    <= 1'b0;
        end
        else
        begin
            carry_prev <= carry_src;
            cascade    <= cascade_src;
        end
    end
endmodule : plc_fabric_model

`default_nettype wire

/* testbench/programmable_logic_element_test.sv */
// Self-checking bench for the programmable logic cell
`timescale 1ns/1ps
`default_nettype none

module programmable_logic_element_test;
    logic                 pclk, presetn, psel, penable, pwrite;
    logic                 pready, pslverr, ctrl_int, carry_grp;
    logic                 local_out, row_out, carry_next_out, cascade_out, carry_group_out;
    logic                 g_carry_next, g_carry_group;
    logic                 carry_src, cascade_src, carry_prev, cascade, q, t, cin, jin;
    logic [11:0]          paddr;
    logic [31:0]          pwdata, prdata;
    logic [3:0]           dat, global_int, idx;
    logic [5:0]           dedicated_in;
    logic [15:0]          lut;
    plc_pkg::plc_cfg_type cfg;
    wire  plc_pkg::plc_cell_in_type cell_in;
    int                   n_mismatch, n_checks, seed, i;

    assign cell_in = {dat, carry_prev, carry_grp, cascade};

    plc_logic_cell #(.CELL_POS(1)) plc_logic_cell_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .cell_in(cell_in),
        .dedicated_in(dedicated_in), .global_int(global_int), .ctrl_int(ctrl_int),
        .local_out(local_out), .row_out(row_out), .carry_next_out(carry_next_out),
        .carry_group_out(carry_group_out), .cascade_out(cascade_out));

    // First and last cell of a one-cell group: group carry in and out
    plc_logic_cell #(.CELLS_PER_GROUP(1), .CELL_POS(0)) plc_logic_cell_grp_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(), .prdata(),
        .pslverr(), .cell_in(cell_in), .dedicated_in(dedicated_in),
        .global_int(global_int), .ctrl_int(ctrl_int), .local_out(), .row_out(),
        .carry_next_out(g_carry_next), .carry_group_out(g_carry_group),
        .cascade_out());

    plc_fabric_model plc_fabric_model_inst (
        .pclk(pclk), .presetn(presetn), .carry_src(carry_src),
        .cascade_src(cascade_src), .carry_prev(carry_prev), .cascade(cascade));

    always #12.5 pclk = ~pclk;

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
    begin
        n_checks++;
        if (seen !== want)
        begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, want);
        end
    end
    endtask : check

    task automatic give_verdict;
    begin
        if (n_mismatch == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    end
    endtask : give_verdict

    // APB transfer; read data compared when not a write
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic err);
    begin
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        check(pslverr, err);
        if (!wr)
            check(prdata, d);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    end
    endtask : apb

    task automatic setup(input logic [15:0] l);
    begin
        apb(1'b1, plc_pkg::ADDR_CFG, cfg, 1'b0);
        apb(1'b1, plc_pkg::ADDR_LUT, {16'h0000, l}, 1'b0);
    end
    endtask : setup

    task automatic settle;
        repeat (3) @(posedge pclk);
    endtask : settle

    task automatic pulse;
    begin
        ctrl_int <= 1'b1;
        settle;
        ctrl_int <= 1'b0;
        settle;
    end
    endtask : pulse

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0;
        pwdata = '0; dat = '0; global_int = '0; dedicated_in = '0; ctrl_int = 0;
        carry_grp = 0; carry_src = 0; cascade_src = 0; q = 0; seed = 75;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, plc_pkg::ADDR_CFG, plc_pkg::CFG_RESET, 1'b0);
        apb(1'b0, plc_pkg::ADDR_LUT, plc_pkg::LUT_RESET, 1'b0);
        apb(1'b1, plc_pkg::ADDR_STAT, 32'h00000001, 1'b1);
        apb(1'b0, 12'h00c, 32'h00000000, 1'b1);
        // Bypassed table with optional carry input and cascade
        for (i = 0; i < 40; i++)
        begin
            cfg = plc_pkg::CFG_RESET;
            cfg.carry_to_lut = 1'($random(seed));
            cfg.cas_en = 1'($random(seed));
            cfg.cas_or = 1'($random(seed));
            lut = 16'($random(seed));
            setup(lut);
            dat <= 4'($random(seed));
            carry_src <= 1'($random(seed));
            cascade_src <= 1'($random(seed));
            carry_grp <= 1'($random(seed));
            dedicated_in <= 6'($random(seed));
            settle;
            idx = {cfg.carry_to_lut ? carry_prev : dat[0], dat[1], dat[2], dat[3]};
            t = lut[idx];
            if (cfg.cas_en)
                t = cfg.cas_or ? (t | cascade) : (t & cascade);
            check(local_out, t);
            check(row_out, t);
            check(cascade_out, t);
        end
        // Arithmetic: sum and carry tables with cascade
        cfg = plc_pkg::CFG_RESET;
        cfg.mode = plc_pkg::MODE_ARITH;
        cfg.cas_en = 1'b1;
        setup(16'he896);
        for (i = 0; i < 8; i++)
        begin
            dat <= {i[0], i[1], 2'b00};
            carry_src <= i[2];
            carry_grp <= i[2];
            cascade_src <= 1'b1;
            settle;
            t = (i[0] & i[1]) | (i[2] & (i[0] | i[1]));
            check(local_out, ^i[2:0]);
            check(cascade_out, ^i[2:0]);
            check(carry_next_out, t);
            check(carry_group_out, 1'b0);
            check(g_carry_group, t);
            check(g_carry_next, 1'b0);
        end
        cfg.chain_end = 1'b1;
        setup(16'he896);
        settle;
        check(carry_next_out, 1'b0);
        check(g_carry_group, 1'b0);
        // Packed register, all flip-flop kinds, enable, clear and preset
        for (i = 0; i < 32; i++)
        begin
            cfg = plc_pkg::CFG_RESET;
            cfg.bypass = 1'b0;
            cfg.row_sel = i[2];
            cfg.local_sel = ~i[2];
            cfg.ff = plc_pkg::plc_ff_type'(i[1:0]);
            cfg.pack = i[3] ? plc_pkg::PACK_SHARED : plc_pkg::PACK_DIRECT;
            cfg.pack_idx = i[4:3];
            cfg.glob_src = 4'hf;
            cfg.clk_sel = 3'h6;
            cfg.ena_sel = 3'h0;
            cfg.clr_sel = 3'h1;
            cfg.pre_sel = 3'h2;
            lut = 16'($random(seed));
            setup(lut);
            dat <= 4'($random(seed));
            global_int <= {1'b0, ($random(seed) % 6) == 0, ($random(seed) % 6) == 0,
                           1'($random(seed))};
            settle;
            if (i % 3 != 0)
                pulse;
            jin = i[3] ? dat[3 - i[4:3]] : dat[0];
            if (global_int[1])
                q = 1'b0;
            else if (global_int[2])
                q = 1'b1;
            else if (global_int[0] && i % 3 != 0)
                case (i[1:0])
                    2'h0: q = jin;
                    2'h1: q = q ^ jin;
                    2'h2: q = (jin & dat[1]) ? ~q : jin ? 1'b1 : dat[1] ? 1'b0 : q;
                    default: q = jin ? 1'b1 : dat[1] ? 1'b0 : q;
                endcase
            t = lut[{i[3] & dat[0], dat[1], dat[2], dat[3]}];
            check(i[2] ? row_out : local_out, q);
            check(i[2] ? local_out : row_out, t);
            global_int <= 4'h0;
            settle;
        end
        // Up/down counter with load
        cfg = plc_pkg::CFG_RESET;
        cfg.mode = plc_pkg::MODE_COUNT;
        cfg.bypass = 1'b0;
        cfg.row_sel = 1'b1;
        cfg.local_sel = 1'b1;
        cfg.clk_sel = 3'h6;
        setup(16'h905a);
        for (i = 0; i < 24; i++)
        begin
            dat <= 4'($random(seed));
            carry_src <= 1'($random(seed));
            settle;
            cin = carry_prev;
            pulse;
            if (dat[1])
                q = dat[0];
            else if (dat[2])
                q = q ^ cin;
            check(row_out, q);
            check(carry_next_out, cin & (dat[3] ? q : ~q));
        end
        give_verdict;
    end

    // Watchdog
    initial
    begin
        #1ms;
        n_mismatch++;
        give_verdict;
    end
endmodule : programmable_logic_element_test

`default_nettype wire
